// *** rtl/dsc_pkg.sv ***
// Package of register map, field layout and encodings for the deadband shutdown control block.
package dsc_pkg;
    // ****************************************************************
    // Register indices; the byte address is four times the index.
    // ****************************************************************
    localparam logic [9:0] DSC_IDX_DB0 = 10'h0c1;
    localparam logic [9:0] DSC_IDX_DB1 = 10'h0c2;
    localparam logic [9:0] DSC_IDX_EN_POL = 10'h0c3;
    localparam logic [9:0] DSC_IDX_CH0_LVL = 10'h0c4;
    localparam logic [9:0] DSC_IDX_CH0_SD = 10'h0c5;
    localparam logic [9:0] DSC_IDX_CH1_LVL = 10'h0c6;
    localparam logic [9:0] DSC_IDX_CH1_SD = 10'h0c7;
    localparam logic [9:0] DSC_IDX_IRQ_STAT = 10'h0d0;
    localparam logic [9:0] DSC_IDX_IRQ_EN = 10'h0d1;
    localparam logic [9:0] DSC_IDX_IRQ_CLR = 10'h0d2;
    // ****************************************************************
    // Field positions, masks and reset values.
    // ****************************************************************
    localparam int DSC_SD_FLAG_BIT = 7;
    localparam int DSC_SD_ARS_BIT = 6;
    localparam int DSC_SD_DBM_HI_BIT = 5;
    localparam int DSC_SD_CMP_BIT = 2;
    localparam int DSC_SD_PIN_BIT = 1;
    localparam int DSC_SD_DIR_BIT = 0;
    localparam logic [7:0] DSC_SD_MASK = 8'hf7;
    localparam int DSC_LVL_B_LSB = 6;
    localparam int DSC_LVL_A_LSB = 4;
    localparam int DSC_LVL_SRC_LSB = 0;
    localparam int DSC_EN_STRIDE = 4;
    localparam int DSC_EN_BIT = 3;
    localparam int DSC_POLB_BIT = 2;
    localparam int DSC_POLA_BIT = 1;
    localparam logic [7:0] DSC_REG_RESET = 8'h00;
    localparam logic [5:0] DSC_DB_RESET = 6'h00;
    localparam logic [3:0] DSC_IRQ_RESET = 4'h0;
    localparam int DSC_IRQ_SD_LSB = 0;
    localparam int DSC_IRQ_RS_LSB = 2;
    // ****************************************************************
    // Shutdown level codes and source codes.
    // ****************************************************************
    localparam logic [1:0] DSC_LVL_HIGH = 2'h3;
    localparam logic [1:0] DSC_LVL_LOW = 2'h2;
    localparam logic [1:0] DSC_LVL_HIZ = 2'h1;
    localparam logic [1:0] DSC_LVL_DEADBAND = 2'h0;
    localparam logic [3:0] DSC_SRC_CMP1 = 4'h0;
    localparam logic [3:0] DSC_SRC_PWM_FIRST = 4'h1;
    localparam logic [3:0] DSC_SRC_PWM_LAST = 4'h6;
    localparam logic [3:0] DSC_SRC_EXT = 4'h7;
    localparam logic [3:0] DSC_SRC_T2 = 4'hf;
    // ****************************************************************
    // Synchroniser lanes for inputs from pins.
    // ****************************************************************
    localparam int DSC_SYNC_W = 4;
    localparam int DSC_SYNC_CMP1 = 0;
    localparam int DSC_SYNC_EXT = 1;
    localparam int DSC_SYNC_PIN0 = 2;
    localparam int DSC_SYNC_PIN1 = 3;
    typedef enum logic [1:0] {DSC_RUN, DSC_SHUT, DSC_WAIT_EDGE} dsc_state_type;
endpackage : dsc_pkg

// *** rtl/dsc_channel.sv ***
// One complementary deadband channel with shutdown output levels.
`timescale 1ns/10ps
`default_nettype none
module dsc_channel #(
    parameter int CNT_W = 6
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_enable,
    input wire logic i_wave,
    input wire logic [CNT_W-1:0] i_lead,
    input wire logic [CNT_W-1:0] i_trail,
    input wire logic i_pol_a,
    input wire logic i_pol_b,
    input wire logic i_shutdown,
    input wire logic [1:0] i_level_a,
    input wire logic [1:0] i_level_b,
    output logic o_out_a,
    output logic o_out_a_oe,
    output logic o_out_b,
    output logic o_out_b_oe
);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    dsc_pkg::dsc_state_type state, next_state;
    logic wave_q, next_wave_q;
    logic [CNT_W-1:0] cnt, next_cnt, sd_cnt, next_sd_cnt;
    logic next_out_a, next_out_a_oe, next_out_b, next_out_b_oe;
    logic rise, raw_a, raw_b, elapsed;

    // Pin value and enable for one output in a shutdown state.
    function automatic logic [1:0] shut_pin(input logic [1:0] code, input logic normal,
                                            input logic idle, input logic done);
        logic [1:0] res;
        res = {idle, 1'b1};
        unique case (code)
            dsc_pkg::DSC_LVL_HIGH: res = 2'h3;
            dsc_pkg::DSC_LVL_LOW: res = 2'h1;
            dsc_pkg::DSC_LVL_HIZ: res = 2'h0;
            dsc_pkg::DSC_LVL_DEADBAND: res = {(done ? idle : normal), 1'b1};
        endcase
        return res;
    endfunction : shut_pin

    // ****************************************************************
    // Deadband timing and shutdown sequencing.
    // ****************************************************************
    always_comb begin
        logic [1:0] pa, pb;
        pa = 2'h0;
        pb = 2'h0;
        next_wave_q = i_wave;
        rise = i_wave & ~wave_q;
        if (i_wave != wave_q) begin
            next_cnt = CNT_ZERO;
        end else if (cnt == CNT_MAX) begin
            next_cnt = cnt;
        end else begin
            next_cnt = cnt + CNT_ONE;
        end
        // Each output waits out its own deadband after the opposite edge.
        raw_a = wave_q & (cnt >= i_lead);
        raw_b = ~wave_q & (cnt >= i_trail);
        elapsed = sd_cnt >= i_lead;
        next_state = state;
        unique case (state)
            dsc_pkg::DSC_RUN: begin
                if (i_shutdown) begin
                    next_state = dsc_pkg::DSC_SHUT;
                end
            end
            dsc_pkg::DSC_SHUT: begin
                if (!i_shutdown) begin
                    next_state = dsc_pkg::DSC_WAIT_EDGE;
                end
            end
            dsc_pkg::DSC_WAIT_EDGE: begin
                if (i_shutdown) begin
                    next_state = dsc_pkg::DSC_SHUT;
                end else if (rise) begin
                    next_state = dsc_pkg::DSC_RUN;
                end
            end
        endcase
        if (state == dsc_pkg::DSC_RUN) begin
            next_sd_cnt = CNT_ZERO;
        end else if (sd_cnt == CNT_MAX) begin
            next_sd_cnt = sd_cnt;
        end else begin
            next_sd_cnt = sd_cnt + CNT_ONE;
        end
        if (!i_enable) begin
            next_out_a = i_pol_a;
            next_out_a_oe = 1'b1;
            next_out_b = i_pol_b;
            next_out_b_oe = 1'b1;
        end else if (state == dsc_pkg::DSC_RUN) begin
            next_out_a = raw_a ^ i_pol_a;
            next_out_a_oe = 1'b1;
            next_out_b = raw_b ^ i_pol_b;
            next_out_b_oe = 1'b1;
        end else begin
            // Levels hold through the wait for the first rising edge.
            pa = shut_pin(i_level_a, raw_a ^ i_pol_a, i_pol_a,
                          elapsed || state == dsc_pkg::DSC_WAIT_EDGE);
            pb = shut_pin(i_level_b, raw_b ^ i_pol_b, i_pol_b,
                          elapsed || state == dsc_pkg::DSC_WAIT_EDGE);
            next_out_a = pa[1];
            next_out_a_oe = pa[0];
            next_out_b = pb[1];
            next_out_b_oe = pb[0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            state <= dsc_pkg::DSC_RUN;
            wave_q <= 1'b0;
            cnt <= CNT_ZERO;
            sd_cnt <= CNT_ZERO;
            o_out_a <= 1'b0;
            o_out_a_oe <= 1'b1;
            o_out_b <= 1'b0;
            o_out_b_oe <= 1'b1;
        end else begin
            state <= next_state;
            wave_q <= next_wave_q;
            cnt <= next_cnt;
            sd_cnt <= next_sd_cnt;
            o_out_a <= next_out_a;
            o_out_a_oe <= next_out_a_oe;
            o_out_b <= next_out_b;
            o_out_b_oe <= next_out_b_oe;
        end
    end
endmodule : dsc_channel
`default_nettype wire

// *** rtl/dsc_top.sv ***
// Deadband shutdown control for channels 0 and 1 with an APB register slave.
//
// Notes on behaviour
// - Bit 7 of each shutdown control register reads 1 during a shutdown event.
// - Bit 6 enables automatic restart from shutdown.
// - Channel 0 mode 0x: lead from count 0, trail count 1; else both count 0.
// - Channel 1 always takes both deadbands from count 1.
// - Bit 2 set: high synchronized comparator output forces shutdown.
// - Bit 1 set: high channel shutdown pin forces shutdown.
// - Channel 0 bit 0 routes output A to its dedicated pin, else alternate pin.
// - Shutdown B level: 11 high, 10 low, 01 tri-state, polarity ignored.
// - Level 00 goes inactive after the deadband, polarity still applied.
// - Bits 5:4 give output A's shutdown level, same coding as B.
// - Source codes: comparator 1, PWM 0 to 5, external, timer-2; others reserved.
// - Automatic restart clears the flag once all enabled sources are low.
// - After clearing, shutdown levels hold until the source's next rising edge.
`timescale 1ns/10ps
`default_nettype none
module dsc_top #(
    parameter int ADDR_W = 12,
    parameter int CNT_W = 6
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_comparator_out_synced,
    input wire logic i_comparator_one,
    input wire logic i_ext_wave,
    input wire logic [5:0] i_pwm,
    input wire logic i_timer2_compare_out,
    input wire logic i_ch0_shutdown_pin,
    input wire logic i_ch1_shutdown_pin,
    output logic o_ch0_out_a,
    output logic o_ch0_out_a_oe,
    output logic o_ch0_alt_out,
    output logic o_ch0_alt_out_oe,
    output logic o_ch0_out_b,
    output logic o_ch0_out_b_oe,
    output logic o_ch1_out_a,
    output logic o_ch1_out_a_oe,
    output logic o_ch1_out_b,
    output logic o_ch1_out_b_oe,
    output logic o_irq
);
    localparam int W = dsc_pkg::DSC_SYNC_W;

    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************
    logic [W-1:0] sync1, sync2, sync3, pin_f;
    logic [W-1:0] next_sync1, next_pin_f;

    always_comb begin
        next_sync1[dsc_pkg::DSC_SYNC_CMP1] = i_comparator_one;
        next_sync1[dsc_pkg::DSC_SYNC_EXT] = i_ext_wave;
        next_sync1[dsc_pkg::DSC_SYNC_PIN0] = i_ch0_shutdown_pin;
        next_sync1[dsc_pkg::DSC_SYNC_PIN1] = i_ch1_shutdown_pin;
        // A change is accepted only once the last two stages agree.
        next_pin_f = (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & pin_f);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pin_f <= '0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= sync1;
            sync3 <= sync2;
            pin_f <= next_pin_f;
        end
    end

    // ****************************************************************
    // Registers and APB slave.
    // ****************************************************************
    logic [7:0] sd_ctrl [2];
    logic [7:0] next_sd_ctrl [2];
    logic [7:0] lvl [2];
    logic [7:0] next_lvl [2];
    logic [7:0] en_pol, next_en_pol;
    logic [CNT_W-1:0] db0, db1, next_db0, next_db1;
    logic [3:0] irq_stat, irq_en, next_irq_stat, next_irq_en;
    logic next_irq, next_pready, next_pslverr;
    logic [31:0] next_prdata;
    logic [9:0] idx;
    logic wr, mapped;
    logic [7:0] rd_val;
    logic [1:0] active, sd_evt, rs_evt;
    logic [9:0] sd_idx [2];
    logic [9:0] lvl_idx [2];

    assign sd_idx[0] = dsc_pkg::DSC_IDX_CH0_SD;
    assign sd_idx[1] = dsc_pkg::DSC_IDX_CH1_SD;
    assign lvl_idx[0] = dsc_pkg::DSC_IDX_CH0_LVL;
    assign lvl_idx[1] = dsc_pkg::DSC_IDX_CH1_LVL;

    always_comb begin
        idx = i_paddr[11:2];
        wr = i_psel & i_penable & o_pready & i_pwrite;
        mapped = (i_paddr[1:0] == 2'h0) && ((i_paddr >> 12) == '0);
        rd_val = 8'h00;
        unique case (idx)
            dsc_pkg::DSC_IDX_DB0: rd_val = 8'(db0);
            dsc_pkg::DSC_IDX_DB1: rd_val = 8'(db1);
            dsc_pkg::DSC_IDX_EN_POL: rd_val = en_pol;
            dsc_pkg::DSC_IDX_CH0_LVL: rd_val = lvl[0];
            dsc_pkg::DSC_IDX_CH0_SD: rd_val = sd_ctrl[0];
            dsc_pkg::DSC_IDX_CH1_LVL: rd_val = lvl[1];
            dsc_pkg::DSC_IDX_CH1_SD: rd_val = sd_ctrl[1];
            dsc_pkg::DSC_IDX_IRQ_STAT: rd_val = 8'(irq_stat);
            dsc_pkg::DSC_IDX_IRQ_EN: rd_val = 8'(irq_en);
            dsc_pkg::DSC_IDX_IRQ_CLR: rd_val = 8'h00;
            default: mapped = 1'b0;
        endcase
        // Answer is prepared in the setup cycle and shown in the access cycle.
        next_pready = i_psel & ~i_penable;
        next_pslverr = i_psel & ~i_penable & ~mapped;
        next_prdata = (i_psel & ~i_penable & ~i_pwrite & mapped) ? 32'(rd_val) : 32'h0;
        next_db0 = (wr && idx == dsc_pkg::DSC_IDX_DB0) ? i_pwdata[CNT_W-1:0] : db0;
        next_db1 = (wr && idx == dsc_pkg::DSC_IDX_DB1) ? i_pwdata[CNT_W-1:0] : db1;
        next_en_pol = (wr && idx == dsc_pkg::DSC_IDX_EN_POL) ? i_pwdata[7:0] : en_pol;
        next_irq_en = (wr && idx == dsc_pkg::DSC_IDX_IRQ_EN) ? i_pwdata[3:0] : irq_en;
        for (int c = 0; c < 2; c++) begin
            next_lvl[c] = (wr && idx == lvl_idx[c]) ? i_pwdata[7:0] : lvl[c];
            active[c] = (sd_ctrl[c][dsc_pkg::DSC_SD_CMP_BIT] & i_comparator_out_synced)
                | (sd_ctrl[c][dsc_pkg::DSC_SD_PIN_BIT]
                   & pin_f[dsc_pkg::DSC_SYNC_PIN0 + c]);
            next_sd_ctrl[c] = sd_ctrl[c];
            if (wr && idx == sd_idx[c]) begin
                next_sd_ctrl[c] = i_pwdata[7:0] & dsc_pkg::DSC_SD_MASK;
            end
            // A live source beats both a software clear and the restart.
            if (active[c]) begin
                next_sd_ctrl[c][dsc_pkg::DSC_SD_FLAG_BIT] = 1'b1;
            end else if (sd_ctrl[c][dsc_pkg::DSC_SD_ARS_BIT]
                         && sd_ctrl[c][dsc_pkg::DSC_SD_FLAG_BIT]) begin
                next_sd_ctrl[c][dsc_pkg::DSC_SD_FLAG_BIT] = 1'b0;
            end
            sd_evt[c] = next_sd_ctrl[c][dsc_pkg::DSC_SD_FLAG_BIT]
                & ~sd_ctrl[c][dsc_pkg::DSC_SD_FLAG_BIT];
            rs_evt[c] = ~next_sd_ctrl[c][dsc_pkg::DSC_SD_FLAG_BIT]
                & sd_ctrl[c][dsc_pkg::DSC_SD_FLAG_BIT];
        end
        next_irq_stat = irq_stat;
        if (wr && idx == dsc_pkg::DSC_IDX_IRQ_CLR) begin
            next_irq_stat = irq_stat & ~i_pwdata[3:0];
        end
        // New events win over a clear in the same cycle.
        next_irq_stat[dsc_pkg::DSC_IRQ_SD_LSB +: 2] =
            next_irq_stat[dsc_pkg::DSC_IRQ_SD_LSB +: 2] | sd_evt;
        next_irq_stat[dsc_pkg::DSC_IRQ_RS_LSB +: 2] =
            next_irq_stat[dsc_pkg::DSC_IRQ_RS_LSB +: 2] | rs_evt;
        next_irq = |(next_irq_stat & next_irq_en);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            for (int c = 0; c < 2; c++) begin
                sd_ctrl[c] <= dsc_pkg::DSC_REG_RESET;
                lvl[c] <= dsc_pkg::DSC_REG_RESET;
            end
            en_pol <= dsc_pkg::DSC_REG_RESET;
            db0 <= CNT_W'(dsc_pkg::DSC_DB_RESET);
            db1 <= CNT_W'(dsc_pkg::DSC_DB_RESET);
            irq_stat <= dsc_pkg::DSC_IRQ_RESET;
            irq_en <= dsc_pkg::DSC_IRQ_RESET;
            o_irq <= 1'b0;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                sd_ctrl[c] <= next_sd_ctrl[c];
                lvl[c] <= next_lvl[c];
            end
            en_pol <= next_en_pol;
            db0 <= next_db0;
            db1 <= next_db1;
            irq_stat <= next_irq_stat;
            irq_en <= next_irq_en;
            o_irq <= next_irq;
            o_pready <= next_pready;
            o_pslverr <= next_pslverr;
            o_prdata <= next_prdata;
        end
    end

    // ****************************************************************
    // Source selection and deadband selection.
    // ****************************************************************
    function automatic logic pick_wave(input logic [3:0] code, input logic [5:0] pwm,
                                       input logic cmp1, input logic ext, input logic t2);
        logic res;
        res = 1'b0;
        if (code == dsc_pkg::DSC_SRC_CMP1) begin
            res = cmp1;
        end else if (code == dsc_pkg::DSC_SRC_EXT) begin
            res = ext;
        end else if (code == dsc_pkg::DSC_SRC_T2) begin
            res = t2;
        end else if (code >= dsc_pkg::DSC_SRC_PWM_FIRST && code <= dsc_pkg::DSC_SRC_PWM_LAST) begin
            res = pwm[3'(code - dsc_pkg::DSC_SRC_PWM_FIRST)];
        end
        return res;
    endfunction : pick_wave

    logic [1:0] wave;
    logic [CNT_W-1:0] lead [2];
    logic [CNT_W-1:0] trail [2];
    logic [1:0] out_a, out_a_oe, out_b, out_b_oe;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            wave[c] = pick_wave(lvl[c][dsc_pkg::DSC_LVL_SRC_LSB +: 4], i_pwm,
                                pin_f[dsc_pkg::DSC_SYNC_CMP1], pin_f[dsc_pkg::DSC_SYNC_EXT],
                                i_timer2_compare_out);
        end
        lead[0] = db0;
        trail[0] = sd_ctrl[0][dsc_pkg::DSC_SD_DBM_HI_BIT] ? db0 : db1;
        lead[1] = db1;
        trail[1] = db1;
    end

    // ****************************************************************
    // Channels.
    // ****************************************************************
    for (genvar c = 0; c < 2; c++) begin : g_ch
        dsc_channel #(
            .CNT_W(CNT_W)
        ) u_channel (
            .i_core_clk(i_core_clk),
            .i_rst_b(i_rst_b),
            .i_enable(en_pol[c * dsc_pkg::DSC_EN_STRIDE + dsc_pkg::DSC_EN_BIT]),
            .i_wave(wave[c]),
            .i_lead(lead[c]),
            .i_trail(trail[c]),
            .i_pol_a(en_pol[c * dsc_pkg::DSC_EN_STRIDE + dsc_pkg::DSC_POLA_BIT]),
            .i_pol_b(en_pol[c * dsc_pkg::DSC_EN_STRIDE + dsc_pkg::DSC_POLB_BIT]),
            .i_shutdown(sd_ctrl[c][dsc_pkg::DSC_SD_FLAG_BIT]),
            .i_level_a(lvl[c][dsc_pkg::DSC_LVL_A_LSB +: 2]),
            .i_level_b(lvl[c][dsc_pkg::DSC_LVL_B_LSB +: 2]),
            .o_out_a(out_a[c]),
            .o_out_a_oe(out_a_oe[c]),
            .o_out_b(out_b[c]),
            .o_out_b_oe(out_b_oe[c])
        );
    end

    // ****************************************************************
    // Output pin stage.
    // ****************************************************************
    logic next_a0, next_a0_oe, next_alt0, next_alt0_oe;

    always_comb begin
        // The unused pin of channel 0's A pair is released.
        next_a0 = out_a[0];
        next_alt0 = out_a[0];
        next_a0_oe = out_a_oe[0] & sd_ctrl[0][dsc_pkg::DSC_SD_DIR_BIT];
        next_alt0_oe = out_a_oe[0] & ~sd_ctrl[0][dsc_pkg::DSC_SD_DIR_BIT];
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_ch0_out_a <= 1'b0;
            o_ch0_out_a_oe <= 1'b0;
            o_ch0_alt_out <= 1'b0;
            o_ch0_alt_out_oe <= 1'b0;
            o_ch0_out_b <= 1'b0;
            o_ch0_out_b_oe <= 1'b0;
            o_ch1_out_a <= 1'b0;
            o_ch1_out_a_oe <= 1'b0;
            o_ch1_out_b <= 1'b0;
            o_ch1_out_b_oe <= 1'b0;
        end else begin
            o_ch0_out_a <= next_a0;
            o_ch0_out_a_oe <= next_a0_oe;
            o_ch0_alt_out <= next_alt0;
            o_ch0_alt_out_oe <= next_alt0_oe;
            o_ch0_out_b <= out_b[0];
            o_ch0_out_b_oe <= out_b_oe[0];
            o_ch1_out_a <= out_a[1];
            o_ch1_out_a_oe <= out_a_oe[1];
            o_ch1_out_b <= out_b[1];
            o_ch1_out_b_oe <= out_b_oe[1];
        end
    end
endmodule : dsc_top
`default_nettype wire

// *** sim/dsc_top_asserts.sv ***
// Checker for the port behaviour of the deadband shutdown control block.
`timescale 1ns/10ps
`default_nettype none
module dsc_top_asserts (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_irq,
    input wire logic o_ch0_out_a_oe,
    input wire logic o_ch0_alt_out_oe,
    input wire logic o_ch1_out_a_oe,
    input wire logic o_ch1_out_b_oe
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    access_ready_a: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    ready_cause_a: assert property (o_pready |-> $past(i_psel && !i_penable))
        else $error("ready without setup");
    ready_single_a: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("error response malformed");
    rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside access");
    direct_excl_a: assert property (!(o_ch0_out_a_oe && o_ch0_alt_out_oe))
        else $error("both channel 0 A pins driven");
    release_drive_a: assert property ($rose(i_rst_b) |-> ##[1:3] o_ch1_out_b_oe)
        else $error("pins not driven after reset");
    reset_quiet_a: assert property (disable iff (1'b0) !i_rst_b |=> !o_pready && !o_irq
        && !o_ch1_out_a_oe) else $error("outputs active in reset");
    cover property (o_pslverr);
    cover property (o_irq);
    cover property ($fell(o_ch1_out_a_oe));
endmodule : dsc_top_asserts
bind dsc_top dsc_top_asserts i_dsc_top_asserts (.i_core_clk, .i_rst_b, .i_psel, .i_penable,
    .o_prdata, .o_pready, .o_pslverr, .o_irq, .o_ch0_out_a_oe, .o_ch0_alt_out_oe,
    .o_ch1_out_a_oe, .o_ch1_out_b_oe);
`default_nettype wire

// *** sim/dsc_switch_model.sv ***
// Power switch pair driven by one channel; a released gate drifts from its last level.
`timescale 1ns/10ps
`default_nettype none
module dsc_switch_model (
    input wire logic i_core_clk,
    input wire logic i_out_a,
    input wire logic i_out_a_oe,
    input wire logic i_out_b,
    input wire logic i_out_b_oe,
    output logic o_pin_a,
    output logic o_pin_b
);
    logic last_a;
    logic last_b;
    always_ff @(posedge i_core_clk) begin
        if (i_out_a_oe) last_a <= i_out_a;
        if (i_out_b_oe) last_b <= i_out_b;
    end
    assign o_pin_a = i_out_a_oe ? i_out_a : ~last_a;
    assign o_pin_b = i_out_b_oe ? i_out_b : ~last_b;
endmodule : dsc_switch_model
`default_nettype wire

// *** sim/dsc_top_tb_top.sv ***
// Register level testbench for the deadband shutdown control block.
`timescale 1ns/10ps
`default_nettype none
module dsc_top_tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic cmp = 1'b0;
    logic pin1 = 1'b0;
    logic [11:0] pa = 12'h0;
    logic [31:0] pwd = 32'h0;
    logic [5:0] pwm = 6'h0;
    logic [31:0] prd;
    logic prdy, perr, a0, a0e, alt, alte, b0, b0e, a1, a1e, b1, b1e, irq, pin_a, pin_b;
    int err_total = 0;
    int n_checks = 0;
    int d;
    logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h6, 4'h7, 4'hf};
    dsc_top i_dsc_top (.i_core_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
        .o_pslverr(perr), .i_comparator_out_synced(cmp), .i_comparator_one(1'b0),
        .i_ext_wave(1'b0), .i_pwm(pwm), .i_timer2_compare_out(1'b0),
        .i_ch0_shutdown_pin(1'b0), .i_ch1_shutdown_pin(pin1), .o_ch0_out_a(a0),
        .o_ch0_out_a_oe(a0e), .o_ch0_alt_out(alt), .o_ch0_alt_out_oe(alte), .o_ch0_out_b(b0),
        .o_ch0_out_b_oe(b0e), .o_ch1_out_a(a1), .o_ch1_out_a_oe(a1e), .o_ch1_out_b(b1),
        .o_ch1_out_b_oe(b1e), .o_irq(irq));
    dsc_switch_model i_dsc_switch_model (.i_core_clk(clk), .i_out_a(a1), .i_out_a_oe(a1e),
        .i_out_b(b1), .i_out_b_oe(b1e), .o_pin_a(pin_a), .o_pin_b(pin_b));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // One APB transfer; a read is compared with e and every response with the error flag.
    task automatic apb(logic [11:0] a, logic w, logic [7:0] v, logic [7:0] e, logic er = 0);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= {24'h0, v};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        if (!w) chk("read data", {24'h0, e}, prd);
        chk("slave error", {31'h0, er}, {31'h0, perr});
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    // Cycles from a source edge until each channel's answering output rises, ch1 minus ch0.
    task automatic meas(logic v, output int dd);
        int t0, t1;
        t0 = 0;
        t1 = 0;
        @(posedge clk);
        pwm <= {5'h0, v};
        for (int k = 1; k < 40; k++) begin
            cyc(1);
            if (t0 == 0 && (v ? a0 : b0) === 1'b1) t0 = k;
            if (t1 == 0 && (v ? a1 : b1) === 1'b1) t1 = k;
        end
        dd = t1 - t0;
    endtask : meas
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
    initial begin
        cyc(16);
        rst_b <= 1'b1;
        apb(12'h314, 0, 0, 8'h00);
        apb(12'h31c, 0, 0, 8'h00);
        apb(12'h3fc, 0, 0, 8'h00, 1);
        apb(12'h31c, 1, 8'h3f, 0);
        apb(12'h31c, 0, 0, 8'h37);
        apb(12'h31c, 1, 8'h00, 0);
        foreach (codes[i]) begin
            apb(12'h318, 1, {4'h0, codes[i]}, 0);
            apb(12'h318, 0, 0, {4'h0, codes[i]});
        end
        $display("test registers done");
        apb(12'h30c, 1, 8'h80, 0);
        apb(12'h318, 1, 8'hd1, 0);
        cmp <= 1'b1;
        cyc(8);
        apb(12'h31c, 0, 0, 8'h00);
        apb(12'h31c, 1, 8'h04, 0);
        cyc(8);
        apb(12'h31c, 0, 0, 8'h84);
        chk("pin b level", 1, pin_b);
        chk("a released", 0, a1e);
        chk("pin a level", 1, pin_a);
        chk("irq masked", 0, irq);
        apb(12'h344, 1, 8'h02, 0);
        cyc(2);
        chk("irq raised", 1, irq);
        apb(12'h348, 1, 8'h02, 0);
        cyc(2);
        chk("irq cleared", 0, irq);
        cmp <= 1'b0;
        cyc(8);
        apb(12'h31c, 0, 0, 8'h84);
        apb(12'h31c, 1, 8'h04, 0);
        cyc(8);
        chk("hold until edge", 0, a1e);
        pwm <= 6'h01;
        cyc(8);
        chk("resume at edge", 1, a1e);
        $display("test comparator shutdown done");
        apb(12'h31c, 1, 8'h40, 0);
        pin1 <= 1'b1;
        cyc(8);
        apb(12'h31c, 0, 0, 8'h40);
        apb(12'h31c, 1, 8'h42, 0);
        cyc(8);
        apb(12'h31c, 0, 0, 8'hc2);
        pin1 <= 1'b0;
        cyc(8);
        apb(12'h31c, 0, 0, 8'h42);
        $display("test pin shutdown done");
        apb(12'h30c, 1, 8'h88, 0);
        apb(12'h314, 1, 8'h01, 0);
        cyc(4);
        chk("direct pin", 2'b10, {a0e, alte});
        apb(12'h314, 1, 8'h00, 0);
        cyc(4);
        chk("original pin", 2'b01, {a0e, alte});
        $display("test direct output done");
        apb(12'h304, 1, 8'h02, 0);
        apb(12'h308, 1, 8'h06, 0);
        apb(12'h310, 1, 8'h01, 0);
        apb(12'h318, 1, 8'h01, 0);
        apb(12'h314, 1, 8'h01, 0);
        meas(0, d);
        meas(1, d);
        meas(0, d);
        meas(1, d);
        chk("lead mode 0", 4, d);
        meas(0, d);
        chk("trail mode 0", 0, d);
        apb(12'h314, 1, 8'h21, 0);
        meas(1, d);
        chk("lead mode 2", 4, d);
        meas(0, d);
        chk("trail mode 2", 4, d);
        $display("test deadband select done");
        report_and_stop();
    end
endmodule : dsc_top_tb_top
`default_nettype wire
